/* File: pkg/i2c_byte_pkg.sv */
// Function
// [R1] shift eight data bits out, msb first
// [R2] after byte: scl low, sda released
// [R3] idle step also drives general purpose bits; the code skips this update in omit mode
// [R4] release sda, one more clock, sample ack
// [R5] flush command returns ack result immediately; a flush while busy is held until the ack bit ends
// [R6] ack status true on ack, false nack
// [R7] address byte is address shifted plus flag
// [R8] direction flag one read, zero write
// [R9] push-pull mode: data out, then input
// [R10] host addresses target before data writes
// [R11] release step may be omitted or low
// [R12] three phase clock, data stable both edges
// [R13] peripheral pulls sda low to acknowledge
package i2c_byte_pkg;

    // register map, word index on the plain port
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    localparam logic [3:0] REG_TARGET = 4'h2;
    localparam logic [3:0] REG_GP_DIR = 4'h3;
    localparam logic [3:0] REG_GP_DAT = 4'h4;
    localparam logic [3:0] REG_CFG = 4'h5;
    localparam logic [3:0] REG_DIV = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_REPLY = 4'h8;
    localparam logic [3:0] REG_EV = 4'h9;
    localparam logic [3:0] REG_EV_CLR = 4'hA;
    localparam logic [3:0] REG_EV_EN = 4'hB;

    // command codes written to REG_CMD
    localparam logic [7:0] CMD_SEND_BYTE = 8'h01;
    localparam logic [7:0] CMD_SEND_ADDR = 8'h02;
    localparam logic [7:0] CMD_FLUSH = 8'h87;

    // event bit positions
    localparam int EV_W = 4;
    localparam int EV_DONE = 0;
    localparam int EV_NACK = 1;
    localparam int EV_REPLY = 2;
    localparam int EV_REFUSED = 3;

    // pin positions on the low byte port
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA_OUT = 1;
    localparam int PIN_SDA_IN = 2;
    localparam int GP_LSB = 3;
    localparam int GP_W = 5;

    // sda handling after the byte
    typedef enum logic [1:0] {
        REL_RELEASE,
        REL_OMIT,
        REL_LOW,
        REL_SPARE
    } release_mode_e;

    typedef struct packed {
        release_mode_e release_mode;
        logic open_drain;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{REL_RELEASE, 1'b1};
    localparam logic [GP_W-1:0] GP_DIR_RESET = 5'h00;
    localparam logic [GP_W-1:0] GP_DAT_RESET = 5'h00;

    // timing: scl period, three phases per bit
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int PHASES = 3;
    localparam int PHASE_CYC = SCL_PERIOD_NS / (PHASES * CLK_PERIOD_NS);
    localparam logic [7:0] DIV_RESET = 8'(PHASE_CYC - 1);

endpackage

/* File: rtl/bit_sync.sv */
module bit_sync (
    input wire logic core_clk, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic async_in, // level from outside
    output logic sync_out // level in core_clk domain
);
    logic meta_r;
    logic hold_r;

    // two stages, first read only by the second
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            meta_r <= 1'b1;
            hold_r <= 1'b1;
        end else begin
            meta_r <= async_in;
            hold_r <= meta_r;
        end
    end

    assign sync_out = hold_r;
endmodule

/* File: rtl/phase_tick.sv */
module phase_tick (
    input wire logic core_clk, // system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic run, // count while high
    input wire logic [7:0] div, // cycles per phase minus one
    output logic tick // one-cycle phase enable
);
    logic [7:0] cnt_r;
    logic tick_r;

    // reload while stopped so the first phase is full length
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end else if (!run) begin
            cnt_r <= div;
            tick_r <= 1'b0;
        end else if (cnt_r == 8'h00) begin
            cnt_r <= div;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 8'h01;
            tick_r <= 1'b0;
        end
    end

    assign tick = tick_r;
endmodule

/* File: rtl/i2c_byte_writer.sv */
// The register addresses and the strobed register port were chosen for this implementation.
module i2c_byte_writer
    import i2c_byte_pkg::*;
(
    input wire logic core_clk, // 50 MHz system clock
    input wire logic rst_b, // sync reset, active low
    input wire logic [3:0] reg_addr, // register index
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic [7:0] low_byte_port_in, // pin levels
    output logic [7:0] low_byte_port_out, // pin drive values
    output logic [7:0] low_byte_port_oe_b, // low while driving
    output logic irq // level interrupt
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_REST,
        ST_ACK
    } state_e;

    // forms the address byte from a 7-bit target and a read flag
    function automatic logic [7:0] form_address(input logic [7:0] tgt);
        form_address = {tgt[6:0], tgt[7]}; // [R7] [R8]
    endfunction

    // software visible state
    logic [7:0] data_r;
    logic [7:0] target_r;
    logic [GP_W-1:0] gp_dir_r;
    logic [GP_W-1:0] gp_dat_r;
    cfg_s cfg_r;
    logic [7:0] div_r;
    logic [7:0] reply_r;
    logic [EV_W-1:0] ev_r;
    logic [EV_W-1:0] ev_en_r;
    logic [7:0] rdata_r;
    logic irq_r;

    // engine state
    state_e state_r;
    logic [1:0] ph_r;
    logic [2:0] bit_r;
    logic [7:0] shift_r;
    logic op_addr_r;
    logic ack_r;
    logic addressed_r;
    logic flush_pend_r;

    // line state before the pin stage
    logic scl_r;
    logic sda_r;
    logic sda_drv_r;
    logic [GP_W-1:0] gp_out_r;
    logic [GP_W-1:0] gp_oe_b_r;
    logic [7:0] port_out_r;
    logic [7:0] port_oe_b_r;

    logic sda_in_s;
    logic tick;

    // sda comes from the pin, so it is synchronised first
    bit_sync u_sda_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_in(low_byte_port_in[PIN_SDA_IN]),
        .sync_out(sda_in_s)
    );

    // phase enable for the three phase serial clock
    phase_tick u_phase (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(state_r != ST_IDLE),
        .div(div_r),
        .tick(tick)
    );

    // command decode
    wire busy = (state_r != ST_IDLE);
    wire wr_cmd = reg_wr && (reg_addr == REG_CMD);
    wire is_byte = wr_cmd && (reg_wdata == CMD_SEND_BYTE);
    wire is_addr = wr_cmd && (reg_wdata == CMD_SEND_ADDR);
    wire is_flush = wr_cmd && (reg_wdata == CMD_FLUSH);
    // a data write before any acked address is refused
    wire byte_ok = is_byte && !busy && addressed_r; // [R10]
    wire addr_ok = is_addr && !busy;
    wire refused = (is_byte || is_addr) && !(byte_ok || addr_ok);

    // phase and bit position within the serial frame
    wire ph0 = tick && (ph_r == 2'd0);
    wire ph1 = tick && (ph_r == 2'd1);
    wire ph2 = tick && (ph_r == 2'd2);
    wire last_bit = (bit_r == 3'd7);
    wire ack_end = (state_r == ST_ACK) && ph2;
    // ack is a low sda during the ninth clock
    wire ack_seen = !sda_in_s; // [R13]
    wire flush_now = is_flush && !busy;
    wire flush_late = ack_end && (flush_pend_r || is_flush);

    // events: done, nack, reply delivered, refused command
    wire [EV_W-1:0] ev_set = {
        refused,
        flush_now || flush_late,
        ack_end && !ack_seen,
        ack_end
    };
    wire ev_clr_wr = reg_wr && (reg_addr == REG_EV_CLR);
    wire [EV_W-1:0] ev_clr = ev_clr_wr ? reg_wdata[EV_W-1:0] : '0;
    // set wins over clear in the same cycle
    wire [EV_W-1:0] ev_nxt = (ev_r & ~ev_clr) | ev_set;

    // status word
    wire [7:0] status_w = {4'h0, flush_pend_r, addressed_r, ack_r, busy};

    // read selection, unmapped indices read zero
    wire [7:0] rd_val =
        (reg_addr == REG_DATA) ? data_r :
        (reg_addr == REG_TARGET) ? target_r :
        (reg_addr == REG_GP_DIR) ? {3'h0, gp_dir_r} :
        (reg_addr == REG_GP_DAT) ? {3'h0, gp_dat_r} :
        (reg_addr == REG_CFG) ? {5'h00, cfg_r} :
        (reg_addr == REG_DIV) ? div_r :
        (reg_addr == REG_STATUS) ? status_w :
        (reg_addr == REG_REPLY) ? reply_r :
        (reg_addr == REG_EV) ? {4'h0, ev_r} :
        (reg_addr == REG_EV_EN) ? {4'h0, ev_en_r} :
        8'h00;

    // pin mapping: open-drain only pulls low, push-pull drives
    // sda while sda_drv_r is set and lets it float otherwise
    wire od = cfg_r.open_drain;
    wire scl_out = od ? 1'b0 : scl_r;
    wire scl_oe_b = od ? scl_r : 1'b0;
    wire sda_out = od ? 1'b0 : sda_r;
    wire sda_oe_b = od ? (sda_r || !sda_drv_r) : !sda_drv_r; // [R9]
    wire [7:0] port_out_nxt = {gp_out_r, 1'b0, sda_out, scl_out};
    wire [7:0] port_oe_b_nxt = {gp_oe_b_r, 1'b1, sda_oe_b, scl_oe_b};

    // configuration registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            data_r <= 8'h00;
            target_r <= 8'h00;
            gp_dir_r <= GP_DIR_RESET;
            gp_dat_r <= GP_DAT_RESET;
            cfg_r <= CFG_RESET;
            div_r <= DIV_RESET;
            ev_en_r <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_DATA: data_r <= reg_wdata;
                REG_TARGET: target_r <= reg_wdata;
                REG_GP_DIR: gp_dir_r <= reg_wdata[GP_W-1:0];
                REG_GP_DAT: gp_dat_r <= reg_wdata[GP_W-1:0];
                REG_CFG: cfg_r <= cfg_s'(reg_wdata[2:0]);
                REG_DIV: div_r <= reg_wdata;
                REG_EV_EN: ev_en_r <= reg_wdata[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rd_val : 8'h00;
        end
    end

    // sticky events and the interrupt level
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ev_r <= '0;
            irq_r <= 1'b0;
        end else begin
            ev_r <= ev_nxt;
            irq_r <= |(ev_nxt & ev_en_r);
        end
    end

    // frame sequencer: byte, idle step, ack bit
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            ph_r <= 2'd0;
            bit_r <= 3'd0;
            shift_r <= 8'h00;
            op_addr_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    ph_r <= 2'd0;
                    bit_r <= 3'd0;
                    if (addr_ok) begin
                        shift_r <= form_address(target_r);
                        op_addr_r <= 1'b1;
                        state_r <= ST_SHIFT;
                    end else if (byte_ok) begin
                        shift_r <= data_r;
                        op_addr_r <= 1'b0;
                        state_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (ph2) begin
                        ph_r <= 2'd0;
                        shift_r <= {shift_r[6:0], 1'b0}; // [R1]
                        bit_r <= bit_r + 3'd1;
                        if (last_bit) begin
                            state_r <= ST_REST;
                        end
                    end else if (tick) begin
                        ph_r <= ph_r + 2'd1;
                    end
                end
                ST_REST: begin
                    // one phase of idle before the ack clock
                    if (tick) begin
                        state_r <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (ph2) begin
                        ph_r <= 2'd0;
                        state_r <= ST_IDLE;
                    end else if (tick) begin
                        ph_r <= ph_r + 2'd1;
                    end
                end
            endcase
        end
    end

    // serial lines: data moves only while scl is low, so it is
    // stable across both the rising and the falling edge
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            sda_drv_r <= 1'b0;
        end else if (state_r == ST_SHIFT) begin
            if (ph0) begin
                scl_r <= 1'b0;
                sda_r <= shift_r[7]; // [R1]
                sda_drv_r <= 1'b1; // [R9]
            end else if (ph1) begin
                scl_r <= 1'b1; // [R12]
            end else if (ph2) begin
                scl_r <= 1'b0; // [R12]
            end
        end else if (state_r == ST_REST && tick) begin
            scl_r <= 1'b0; // [R2]
            unique case (cfg_r.release_mode)
                REL_OMIT: ; // [R11]
                REL_LOW: begin
                    sda_r <= 1'b0; // [R11]
                    sda_drv_r <= 1'b1;
                end
                default: begin
                    sda_r <= 1'b1; // [R2]
                    sda_drv_r <= 1'b0; // [R9]
                end
            endcase
        end else if (state_r == ST_ACK) begin
            if (ph0) begin
                sda_r <= 1'b1; // [R4]
                sda_drv_r <= 1'b0; // [R9]
            end else if (ph1) begin
                scl_r <= 1'b1; // [R4]
            end else if (ph2) begin
                scl_r <= 1'b0;
                // between transfers sda follows the chosen mode
                if (cfg_r.release_mode == REL_LOW) begin
                    sda_r <= 1'b0; // [R11]
                    sda_drv_r <= 1'b1;
                end
            end
        end
    end

    // general purpose bits follow their registers at the idle
    // step only, and never in omit mode, so a write mid-byte does not glitch the port
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gp_out_r <= GP_DAT_RESET;
            gp_oe_b_r <= ~GP_DIR_RESET;
        end else if (state_r == ST_REST && tick &&
                     cfg_r.release_mode != REL_OMIT) begin
            gp_out_r <= gp_dat_r; // [R3]
            gp_oe_b_r <= ~gp_dir_r; // [R3]
        end
    end

    // ack sampled on the last phase, while scl is still high
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
            addressed_r <= 1'b0;
        end else if (ack_end) begin
            ack_r <= ack_seen; // [R6] [R4]
            if (op_addr_r) begin
                addressed_r <= ack_seen; // [R10]
            end
        end
    end

    // a flush while busy is kept and served when the ack lands
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flush_pend_r <= 1'b0;
            reply_r <= 8'h00;
        end else if (flush_late) begin
            flush_pend_r <= 1'b0;
            reply_r <= {7'h00, ack_seen}; // [R5]
        end else if (flush_now) begin
            reply_r <= {7'h00, ack_r}; // [R5]
        end else if (is_flush) begin
            flush_pend_r <= 1'b1;
        end
    end

    // pin stage, so every port bit comes from a flop
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            port_out_r <= 8'h00;
            port_oe_b_r <= 8'hFF;
        end else begin
            port_out_r <= port_out_nxt;
            port_oe_b_r <= port_oe_b_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = irq_r;
    assign low_byte_port_out = port_out_r;
    assign low_byte_port_oe_b = port_oe_b_r;

endmodule

/* File: verification/i2c_byte_writer_asserts.sv */
module i2c_byte_writer_asserts
    import i2c_byte_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic [3:0] reg_addr, // index
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic [7:0] low_byte_port_in, // pin levels
    input wire logic [7:0] low_byte_port_out, // pin drive
    input wire logic [7:0] low_byte_port_oe_b, // low while driving
    input wire logic irq // interrupt
);
    logic od_m;
    logic [7:0] div_m;
    logic [4:0] dir_m, dat_m;
    logic [8:0] hi_cnt;
    logic seen_fall;
    wire logic scl_lvl = low_byte_port_oe_b[0] | low_byte_port_out[0];
    wire logic [1:0] sda_drv = {low_byte_port_oe_b[1], low_byte_port_out[1]};
    wire logic [4:0] gp_oe_b = low_byte_port_oe_b[7:3];
    wire logic [4:0] gp_out = low_byte_port_out[7:3];

    // mirror of host settings, seen only through the bus
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            od_m <= 1'b1;
            div_m <= DIV_RESET;
            dir_m <= GP_DIR_RESET;
            dat_m <= GP_DAT_RESET;
        end else if (reg_wr) begin
            if (reg_addr == REG_CFG) od_m <= reg_wdata[0];
            if (reg_addr == REG_DIV) div_m <= reg_wdata;
            if (reg_addr == REG_GP_DIR) dir_m <= reg_wdata[4:0];
            if (reg_addr == REG_GP_DAT) dat_m <= reg_wdata[4:0];
        end
    end

    // scl high time; the idle high before the first frame is skipped
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            hi_cnt <= 9'h000;
            seen_fall <= 1'b0;
        end else begin
            hi_cnt <= scl_lvl ? hi_cnt + 9'h001 : 9'h000;
            if (!scl_lvl) seen_fall <= 1'b1;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    unmapped_read_a: assert property (reg_rd && reg_addr > REG_EV_EN
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    spare_pin_a: assert property (low_byte_port_out[2] == 1'b0
        && low_byte_port_oe_b[2] == 1'b1) else $error("sda input driven");
    sda_stable_a: assert property (scl_lvl && $past(scl_lvl)
        |-> $stable(sda_drv)) else $error("sda moved while scl high");
    // pins lag a config write by one cycle, so wait for the mode to settle
    od_zero_a: assert property (od_m && $past(od_m)
        && !low_byte_port_oe_b[1] |-> !low_byte_port_out[1])
        else $error("open drain drove one");
    gp_update_a: assert property ($changed(gp_oe_b) || $changed(gp_out)
        |-> gp_oe_b == ~dir_m && ((gp_out ^ dat_m) & dir_m) == 5'h00)
        else $error("general purpose bits wrong");
    scl_high_a: assert property ($fell(scl_lvl) && seen_fall
        |-> hi_cnt == 9'(div_m) + 9'h001) else $error("scl high time");
    irq_mask_a: assert property (reg_wr && reg_addr == REG_EV_EN
        && reg_wdata == 8'h00 |-> ##2 !irq) else $error("masked irq high");

    // main scenarios
    cover property ($fell(scl_lvl) && seen_fall);
    cover property ($rose(irq));
    cover property (reg_rd && reg_addr == REG_REPLY);
endmodule

bind i2c_byte_writer i2c_byte_writer_asserts i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_byte_port_in(low_byte_port_in),
    .low_byte_port_out(low_byte_port_out),
    .low_byte_port_oe_b(low_byte_port_oe_b), .irq(irq)
);

/* File: verification/i2c_periph_model.sv */
module i2c_periph_model (
    input wire logic rst_b, // reset, active low
    input wire logic scl, // bus clock level
    input wire logic sda, // bus data level
    input wire logic ack_en, // acknowledge the next byte
    output logic sda_pull, // high pulls sda low
    output logic [7:0] rx_byte // last byte taken
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned cnt;
    logic [7:0] shreg;

    // bits taken on rising scl, ack put on while scl is low
    always @(scl or negedge rst_b) begin
        if (!rst_b) begin
            cnt = 0;
            sda_pull = 1'b0;
        end else if (scl === 1'b1) begin
            if (cnt < 8) shreg = {shreg[6:0], sda};
            cnt = cnt + 1;
        end else if (cnt == 8) begin
            sda_pull = ack_en;
        end else if (cnt == 9) begin
            sda_pull = 1'b0;
            cnt = 0;
            rx_byte = shreg;
        end
    end
endmodule

/* File: verification/tb_i2c_byte_writer.sv */
module tb_i2c_byte_writer import i2c_byte_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] EVD = 8'(1 << EV_DONE);
    localparam logic [7:0] EVN = 8'(1 << EV_NACK);
    localparam logic [7:0] EVR = 8'(1 << EV_REFUSED);
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ack_en = 1'b1;
    logic [7:0] reg_rdata, port_out, port_oe_b, rx_byte, v;
    logic irq, sda_pull;
    int mismatches = 0;
    int checks = 0;
    // open-drain wires with pull-ups
    wire logic scl = port_oe_b[0] | port_out[0];
    wire logic sda = (port_oe_b[1] | port_out[1]) & ~sda_pull;

    always #10 core_clk = ~core_clk;

    i2c_byte_writer i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .low_byte_port_in({5'h00, sda, sda, scl}),
        .low_byte_port_out(port_out), .low_byte_port_oe_b(port_oe_b),
        .irq(irq)
    );
    i2c_periph_model i_peer (
        .rst_b(rst_b), .scl(scl), .sda(sda), .ack_en(ack_en),
        .sda_pull(sda_pull), .rx_byte(rx_byte)
    );

    task automatic end_sim();
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data is taken in the one cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        rd(a);
        chk(v, exp);
    endtask
    task automatic wait_idle();
        repeat (300) begin
            rd(REG_STATUS);
            if (v[0] === 1'b0) return;
        end
        mismatches++;
        end_sim();
    endtask
    task automatic xfer(input logic [7:0] cmd, d, input logic ack,
                        input logic [7:0] exp, ev);
        ack_en = ack;
        wr(REG_EV_CLR, 8'hFF);
        wr(REG_DATA, d);
        wr(REG_CMD, cmd);
        wait_idle();
        chk(rx_byte, exp);
        rchk(REG_EV, ev);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        rchk(REG_CFG, 8'(CFG_RESET));
        rchk(REG_DIV, DIV_RESET);
        rchk(REG_GP_DIR, 8'(GP_DIR_RESET));
        rchk(REG_STATUS, 8'h00);
        rchk(4'hF, 8'h00);
        wr(REG_DIV, 8'h01);
        wr(REG_GP_DIR, 8'h15);
        wr(REG_GP_DAT, 8'h0C);
        wr(REG_CMD, CMD_SEND_BYTE);
        rchk(REG_EV, EVR);
        for (int i = 0; i < 2; i++) begin
            wr(REG_TARGET, {i[0], 7'h50});
            xfer(CMD_SEND_ADDR, 8'h00, 1'b1, {7'h50, i[0]}, EVD);
            chk({3'h0, port_oe_b[7:3]}, 8'h0A);
            chk({3'h0, port_out[7:3] & 5'h15}, 8'h04);
            chk({6'h00, scl, port_oe_b[1]}, 8'h01);
            rchk(REG_STATUS, 8'h06);
        end
        xfer(CMD_SEND_BYTE, 8'h96, 1'b1, 8'h96, EVD);
        wr(REG_EV_EN, EVD);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irq}, 8'h01);
        wr(REG_EV_EN, 8'h00);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irq}, 8'h00);
        wr(REG_EV_EN, EVD);
        wr(REG_EV_CLR, EVD);
        repeat (3) @(posedge core_clk);
        chk({7'h00, irq}, 8'h00);
        wr(REG_CMD, CMD_FLUSH);
        rchk(REG_REPLY, 8'h01);
        xfer(CMD_SEND_BYTE, 8'h3C, 1'b0, 8'h3C, EVD | EVN);
        rchk(REG_STATUS, 8'h04);
        wr(REG_CMD, CMD_FLUSH);
        rchk(REG_REPLY, 8'h00);
        // flush held while busy, second send refused
        ack_en = 1'b1;
        wr(REG_DATA, 8'hC3);
        wr(REG_CMD, CMD_SEND_BYTE);
        wr(REG_CMD, CMD_FLUSH);
        wr(REG_CMD, CMD_SEND_BYTE);
        rchk(REG_REPLY, 8'h00);
        wait_idle();
        rchk(REG_REPLY, 8'h01);
        rd(REG_EV);
        chk({7'h00, v[EV_REFUSED]}, 8'h01);
        wr(REG_CFG, {5'h00, REL_LOW, 1'b1});
        xfer(CMD_SEND_BYTE, 8'h5A, 1'b1, 8'h5A, EVD);
        chk({6'h00, port_oe_b[1], port_out[1]}, 8'h00);
        // omit mode: idle step skips the general purpose update, so the bits hold
        wr(REG_CFG, {5'h00, REL_OMIT, 1'b1});
        wr(REG_GP_DAT, 8'h11);
        xfer(CMD_SEND_BYTE, 8'h7E, 1'b1, 8'h7E, EVD);
        chk({3'h0, port_out[7:3] & 5'h15}, 8'h04);
        chk({7'h00, port_oe_b[1]}, 8'h01);
        // push-pull: sda driven only while shifting
        wr(REG_CFG, 8'h00);
        wr(REG_DATA, 8'hA5);
        chk({7'h00, port_oe_b[1]}, 8'h01);
        wr(REG_CMD, CMD_SEND_BYTE);
        repeat (8) @(posedge core_clk);
        #1 chk({7'h00, port_oe_b[1]}, 8'h00);
        wait_idle();
        chk(rx_byte, 8'hA5);
        chk({7'h00, port_oe_b[1]}, 8'h01);
        chk({3'h0, port_out[7:3] & 5'h15}, 8'h11);
        end_sim();
    end
endmodule
